// ---- testbench/tcim_irq_asserts.sv ----
`timescale 1ns/1ps
module tcim_irq_asserts #(parameter int unsigned NUM_CH = 3)
(
   input wire logic sys_clk, resetn, reg_write, reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata, reg_rdata,
   input wire logic [NUM_CH-1:0] counter_overflow_event, load_overrun_event, compare_a_event,
   input wire logic [NUM_CH-1:0] compare_b_event, compare_c_event, capture_a_load_event,
   input wire logic [NUM_CH-1:0] capture_b_load_event, external_trigger_event,
   input wire logic [NUM_CH-1:0] channel_irq, wave_mode
);
   wire logic [NUM_CH-1:0] ev_any = counter_overflow_event | load_overrun_event
      | compare_a_event | compare_b_event | compare_c_event | capture_a_load_event
      | capture_b_load_event | external_trigger_event;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   AST_RD_HIGH: assert property (reg_read |=> reg_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   AST_UNMAPPED: assert property (reg_read && reg_addr >= 8'hc0 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_IRQ_CAUSE: assert property (!reg_write && ev_any == '0 |=>
      (channel_irq & ~$past(channel_irq)) == '0) else $error("irq rose with no cause");
   AST_FLAG_CLR: assert property (reg_read && reg_addr == 8'h20 && !ev_any[0] |=>
      !channel_irq[0]) else $error("irq held after flags read");
   AST_OVF_IRQ: assert property (reg_write && reg_addr == 8'h24 && reg_wdata[0] ##1
      counter_overflow_event[0] && !reg_write |=> channel_irq[0]) else $error("overflow irq");
   AST_EXT_IRQ: assert property (reg_write && reg_addr == 8'ha4 && reg_wdata[7] ##1
      external_trigger_event[2] && !reg_write |=> channel_irq[2]) else $error("trigger irq");
   AST_WAVE_HOLD: assert property (!reg_write |=> $stable(wave_mode))
      else $error("mode changed without a write");
endmodule : tcim_irq_asserts
bind tcim_timer_channel_irq_mask tcim_irq_asserts #(.NUM_CH(NUM_CH)) u_chk (.*);

// ---- testbench/tcim_timer_channel_irq_mask_tb_top.sv ----
`timescale 1ns/1ps
module tcim_timer_channel_irq_mask_tb_top;
   import tcim_pkg::*;
   logic sys_clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
   logic [7:0] reg_addr = '0, b;
   logic [7:0] m [3] = '{default: 8'h00};
   logic [31:0] reg_wdata = '0, reg_rdata, d;
   logic [2:0] ev [8] = '{default: 3'h0};
   logic [2:0] channel_irq, wave_mode, w = '0;
   int mismatches = 0, samples_checked = 0, seed = 34165, c, s, i;
   always #10 sys_clk = ~sys_clk;
   tcim_timer_channel_irq_mask #(.NUM_CH(3)) DUT (.*,
      .counter_overflow_event(ev[0]), .load_overrun_event(ev[1]), .compare_a_event(ev[2]),
      .compare_b_event(ev[3]), .compare_c_event(ev[4]), .capture_a_load_event(ev[5]),
      .capture_b_load_event(ev[6]), .external_trigger_event(ev[7]));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask : rd
   // mode-qualified disables: capture-only bits need wave 0, compare A/B need wave 1
   function automatic logic [7:0] clr_ok(input logic wv);
      return wv ? ~TCIM_CLR_CAPTURE_ONLY : ~TCIM_CLR_WAVE_ONLY;
   endfunction : clr_ok
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      for (c = 0; c < 3; c++) rd(8'(c * 64) + TCIM_OFF_MASK_STATE, 0);
      rd(8'hc4, 0);
      for (i = 0; i < 90; i++)
      begin
         c = {$random(seed)} % 3;
         b = 8'(c * 64);
         d = $random(seed);
         case (i % 3)
            0: wr(b + TCIM_OFF_ENABLE_SET, d);
            1: wr(b + TCIM_OFF_ENABLE_CLEAR, d);
            default: wr(b + TCIM_OFF_WAVE_SEL, d);
         endcase
         if (i % 3 == 0) m[c] |= d[7:0];
         if (i % 3 == 1) m[c] &= ~(d[7:0] & clr_ok(w[c]));
         if (i % 3 == 2) w[c] = d[0];
         rd(b + TCIM_OFF_MASK_STATE, {24'h0, m[c]});
         // write-only registers must read back as zero even with masks set
         if (i % 3 == 0) rd(b + TCIM_OFF_ENABLE_SET, 32'h0);
         if (i % 3 == 1) rd(b + TCIM_OFF_ENABLE_CLEAR, 32'h0);
         if (i % 3 == 2) chk("wave", {29'h0, w}, {29'h0, wave_mode});
      end
      for (c = 0; c < 3; c += 2)
         for (s = 0; s < 8; s++)
         begin
            b = 8'(c * 64);
            d = $random(seed);
            if (s == 0 || s == 7) d[s] = 1'b1;
            wr(b + TCIM_OFF_ENABLE_SET, d);
            m[c] |= d[7:0];
            ev[s][c] <= 1'b1;
            @(posedge sys_clk);
            ev[s][c] <= 1'b0;
            #1 chk("irq", {29'h0, 3'(m[c][s]) << c}, {29'h0, channel_irq});
            rd(b + TCIM_OFF_EVENT_FLAGS, 32'h1 << s);
            chk("irq", 32'h0, {29'h0, channel_irq});
         end
      wrap_up;
   end
endmodule : tcim_timer_channel_irq_mask_tb_top

// ---- verilog/tcim_pkg.sv ----
package tcim_pkg;
   localparam int unsigned TCIM_NUM_CH = 3;
   localparam int unsigned TCIM_NUM_SRC = 8;
   localparam int unsigned TCIM_ADDR_W = 8;
   localparam int unsigned TCIM_DATA_W = 32;
   localparam int unsigned TCIM_CH_STRIDE = 64;
   // per-channel register offsets within the channel slot
   localparam logic [7:0] TCIM_OFF_EVENT_FLAGS = 8'h20;
   localparam logic [7:0] TCIM_OFF_ENABLE_SET = 8'h24;
   localparam logic [7:0] TCIM_OFF_ENABLE_CLEAR = 8'h28;
   localparam logic [7:0] TCIM_OFF_MASK_STATE = 8'h2c;
   localparam logic [7:0] TCIM_OFF_WAVE_SEL = 8'h30;
   localparam logic [7:0] TCIM_OFF_MASK = 8'h3f;
   localparam logic [7:0] TCIM_OFF_SLOT = 8'hc0;
   // source bit positions
   localparam int unsigned TCIM_BIT_COUNTER_OVERFLOW = 0;
   localparam int unsigned TCIM_BIT_LOAD_OVERRUN = 1;
   localparam int unsigned TCIM_BIT_COMPARE_A = 2;
   localparam int unsigned TCIM_BIT_COMPARE_B = 3;
   localparam int unsigned TCIM_BIT_COMPARE_C = 4;
   localparam int unsigned TCIM_BIT_CAPTURE_A_LOAD = 5;
   localparam int unsigned TCIM_BIT_CAPTURE_B_LOAD = 6;
   localparam int unsigned TCIM_BIT_EXTERNAL_TRIGGER = 7;
   // sources whose disable needs capture mode, or waveform mode
   localparam logic [7:0] TCIM_CLR_CAPTURE_ONLY = 8'h62;
   localparam logic [7:0] TCIM_CLR_WAVE_ONLY = 8'h0c;
   localparam logic [7:0] TCIM_MASK_RESET = 8'h00;
   localparam logic [7:0] TCIM_FLAGS_RESET = 8'h00;
   localparam logic TCIM_WAVE_RESET = 1'b0;
endpackage : tcim_pkg

// ---- verilog/tcim_timer_channel_irq_mask.sv ----
// Function
// (RULE_01) Enable bit 0 sets the counter overflow mask and disable bit 0 clears it.
// (RULE_02) Enable bit 1 sets the load overrun mask; disable bit 1 clears it only in capture mode.
// (RULE_03) Enable bit 2 sets the compare A mask; disable bit 2 clears it only in waveform mode.
// (RULE_04) Enable bit 3 sets the compare B mask; disable bit 3 clears it only in waveform mode.
// (RULE_05) Enable bit 4 sets the compare C mask; disable bit 4 clears it in either mode.
// (RULE_06) Enable bit 5 sets the capture A load mask; disable bit 5 clears it only in capture mode.
// (RULE_07) Enable bit 6 sets the capture B load mask; disable bit 6 clears it only in capture mode.
// (RULE_08) Enable bit 7 sets the external trigger mask; disable bit 7 clears it in either mode.
// (RULE_09) Enable and disable registers are write-only and zero bits leave the mask alone.
// (RULE_10) The mask state register reads back the eight current mask bits.
// (RULE_11) A zero mask bit keeps its source from raising the channel interrupt.
// (RULE_12) Each event flag sets on its event and clears when software reads the flags register.
// (RULE_13) A channel interrupt is high while any flag and its mask bit are both one, per channel.
// (RULE_14) Reset clears all masks and bits 31 to 8 are ignored on write and read as zero.
`timescale 1ns/1ps
module tcim_timer_channel_irq_mask
   import tcim_pkg::*;
#(
   parameter int unsigned NUM_CH = tcim_pkg::TCIM_NUM_CH
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire logic [tcim_pkg::TCIM_ADDR_W-1:0] reg_addr,
   input wire logic [tcim_pkg::TCIM_DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [tcim_pkg::TCIM_DATA_W-1:0] reg_rdata,
   // per-channel event pulses, same clock
   input wire logic [NUM_CH-1:0] counter_overflow_event,
   input wire logic [NUM_CH-1:0] load_overrun_event,
   input wire logic [NUM_CH-1:0] compare_a_event,
   input wire logic [NUM_CH-1:0] compare_b_event,
   input wire logic [NUM_CH-1:0] compare_c_event,
   input wire logic [NUM_CH-1:0] capture_a_load_event,
   input wire logic [NUM_CH-1:0] capture_b_load_event,
   input wire logic [NUM_CH-1:0] external_trigger_event,
   // channel interrupts and mode
   output logic [NUM_CH-1:0] channel_irq,
   output logic [NUM_CH-1:0] wave_mode
);
   import tcim_pkg::*;

   localparam int unsigned SW = TCIM_NUM_SRC;

   logic [SW-1:0] mask_q [NUM_CH];
   logic [SW-1:0] flags_q [NUM_CH];
   logic [NUM_CH-1:0] wave_q;
   logic [NUM_CH-1:0] irq_q;
   logic [TCIM_DATA_W-1:0] rdata_q;

   wire [7:0] addr_off = reg_addr & TCIM_OFF_MASK;
   wire [7:0] addr_slot = reg_addr & TCIM_OFF_SLOT;
   wire [SW-1:0] wr_bits = reg_wdata[SW-1:0]; // RULE_14
   wire [SW-1:0] ch_rdata [NUM_CH];
   wire [NUM_CH-1:0] ch_hit;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++)
      begin : g_ch
         wire [SW-1:0] ev;
         wire sel;
         wire wr_set;
         wire wr_clr;
         wire wr_wave;
         wire rd_flags;
         wire [SW-1:0] clr_allowed;
         wire [SW-1:0] set_bits;
         wire [SW-1:0] clr_bits;
         wire [SW-1:0] mask_d;
         wire [SW-1:0] flags_d;

         assign ev = {external_trigger_event[c], capture_b_load_event[c],
            capture_a_load_event[c], compare_c_event[c], compare_b_event[c],
            compare_a_event[c], load_overrun_event[c], counter_overflow_event[c]};
         assign sel = (addr_slot == 8'(c * TCIM_CH_STRIDE));
         assign ch_hit[c] = sel;
         assign wr_set = reg_write && sel && (addr_off == TCIM_OFF_ENABLE_SET);
         assign wr_clr = reg_write && sel && (addr_off == TCIM_OFF_ENABLE_CLEAR);
         assign wr_wave = reg_write && sel && (addr_off == TCIM_OFF_WAVE_SEL);
         assign rd_flags = reg_read && sel && (addr_off == TCIM_OFF_EVENT_FLAGS);
         // mode-qualified disables; compare C, overflow, trigger always clear
         // RULE_02 RULE_03 RULE_04 RULE_06 RULE_07
         assign clr_allowed = wave_q[c] ? ~TCIM_CLR_CAPTURE_ONLY : ~TCIM_CLR_WAVE_ONLY;
         assign set_bits = wr_set ? wr_bits : '0; // RULE_09
         assign clr_bits = wr_clr ? (wr_bits & clr_allowed) : '0; // RULE_01 RULE_05 RULE_08
         assign mask_d = (mask_q[c] & ~clr_bits) | set_bits;
         // an event in the read cycle survives the clear
         assign flags_d = (rd_flags ? '0 : flags_q[c]) | ev; // RULE_12
         assign ch_rdata[c] =
            (addr_off == TCIM_OFF_MASK_STATE) ? mask_q[c] : // RULE_10
            (addr_off == TCIM_OFF_EVENT_FLAGS) ? flags_q[c] :
            (addr_off == TCIM_OFF_WAVE_SEL) ? {{(SW-1){1'b0}}, wave_q[c]} : '0;

         always_ff @(posedge sys_clk)
         begin
            if (!resetn)
            begin
               mask_q[c] <= TCIM_MASK_RESET; // RULE_14
               flags_q[c] <= TCIM_FLAGS_RESET;
               wave_q[c] <= TCIM_WAVE_RESET;
               irq_q[c] <= 1'b0;
            end
            else
            begin
               mask_q[c] <= mask_d;
               flags_q[c] <= flags_d;
               if (wr_wave)
               begin
                  wave_q[c] <= reg_wdata[0];
               end
               irq_q[c] <= |(flags_d & mask_d); // RULE_11 RULE_13
            end
         end
      end
   endgenerate

   // channel select for read data; unmapped reads return zero
   logic [SW-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (ch_hit[i])
         begin
            rd_mux = ch_rdata[i];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= reg_read ? {{(TCIM_DATA_W-SW){1'b0}}, rd_mux} : '0; // RULE_14
      end
   end

   assign reg_rdata = rdata_q;
   assign channel_irq = irq_q;
   assign wave_mode = wave_q;
endmodule : tcim_timer_channel_irq_mask
